// ### core/synth_modem_pkg.sv
// Constants, register map and types for the synthesizer and modem configuration bank
// Behaviour
// - Signed offset byte, times four, is added to the base word.
// - Top two bits of the high carrier byte are read-only zero.
// - Base word is high six bits, middle byte and low byte.
// - Bandwidth exponent and mantissa fields set the ADC decimation ratio.
// - Rate exponent sits in bits 3:0, reset value twelve.
// - Rate mantissa is a full byte, reset value 0x22.
// - Symbol rate step is (256 plus mantissa) shifted by the exponent.
// - Bit 7 of modem format bypasses the DC blocking filter.
// - Modulation format is bits 6:4 of modem format, reset zero.
// - Codes 000, 001, 011, 111 mean 2-FSK, GFSK, ASK/OOK, MSK.
package synth_modem_pkg;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 6;
	localparam int WORD_W = 24;
	localparam int DECIM_W = 9;

	// Register offsets
	localparam logic [5:0] ADDR_CARRIER_WORD_OFFSET = 6'h0C;
	localparam logic [5:0] ADDR_CARRIER_HIGH = 6'h0D;
	localparam logic [5:0] ADDR_CARRIER_MIDDLE = 6'h0E;
	localparam logic [5:0] ADDR_CARRIER_LOW = 6'h0F;
	localparam logic [5:0] ADDR_FILTER_RATE = 6'h10;
	localparam logic [5:0] ADDR_RATE_MANTISSA = 6'h11;
	localparam logic [5:0] ADDR_MODEM_FORMAT = 6'h12;

	// Reset values
	localparam logic [7:0] RST_CARRIER_WORD_OFFSET = 8'h00;
	localparam logic [7:0] RST_CARRIER_HIGH = 8'h1E;
	localparam logic [7:0] RST_CARRIER_MIDDLE = 8'hC4;
	localparam logic [7:0] RST_CARRIER_LOW = 8'hEC;
	localparam logic [7:0] RST_FILTER_RATE = 8'h8C;
	localparam logic [7:0] RST_RATE_MANTISSA = 8'h22;
	localparam logic [7:0] RST_MODEM_FORMAT = 8'h00;
	localparam logic [3:0] RST_RATE_EXP = 4'hC;

	// Writable bit masks
	localparam logic [7:0] MASK_CARRIER_HIGH = 8'h3F;
	localparam logic [7:0] MASK_MODEM_FORMAT = 8'hF0;
	localparam logic [7:0] MASK_FULL = 8'hFF;

	// Field positions
	localparam int BW_EXP_HI = 7;
	localparam int BW_EXP_LO = 6;
	localparam int BW_MANT_HI = 5;
	localparam int BW_MANT_LO = 4;
	localparam int RATE_EXP_HI = 3;
	localparam int RATE_EXP_LO = 0;
	localparam int HIGH_WORD_HI = 5;
	localparam int DC_BYPASS_BIT = 7;
	localparam int MOD_HI = 6;
	localparam int MOD_LO = 4;
	localparam int HDR_READ_BIT = 7;
	localparam int HDR_BURST_BIT = 6;

	// Arithmetic constants
	localparam int OFFSET_SHIFT = 2;
	localparam int DECIM_SCALE_SHIFT = 3;
	localparam logic [2:0] DECIM_BASE = 3'h4;
	localparam logic [8:0] RATE_HIDDEN_ONE = 9'h100;

	// Modulation codes
	localparam logic [2:0] MOD_2FSK = 3'h0;
	localparam logic [2:0] MOD_GFSK = 3'h1;
	localparam logic [2:0] MOD_ASK = 3'h3;
	localparam logic [2:0] MOD_MSK = 3'h7;

	typedef enum logic [1:0] {
		ST_HEADER = 2'b01,
		ST_DATA = 2'b10
	} frame_state_e;
endpackage

// ### core/host_byte_if.sv
// Byte carrier between the serial host port and the register bank
`timescale 1ns/1ps
interface host_byte_if #(parameter int BYTE_W = 8);
	logic frame_active;
	logic rx_valid;
	logic [BYTE_W-1:0] rx_byte;
	logic [BYTE_W-1:0] tx_byte;

	modport port (output frame_active, output rx_valid, output rx_byte, input tx_byte);
	modport regs (input frame_active, input rx_valid, input rx_byte, output tx_byte);
endinterface

// ### core/host_byte_port.sv
// Serial host port: pin synchronisers and byte shifter
`timescale 1ns/1ps
module host_byte_port #(parameter int BYTE_W = 8)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic si,
	input wire logic cs_n,
	output logic so,
	host_byte_if.port bus
);
	localparam int CW = $clog2(BYTE_W);
	localparam logic [CW-1:0] LAST = CW'(BYTE_W - 1);

	generate
		if (BYTE_W < 2)
		begin : g_bad_width
			$error("host_byte_port needs BYTE_W of at least 2");
		end
	endgenerate

	logic sclk_s1, sclk_s2, sclk_s3;
	logic si_s1, si_s2;
	logic cs_s1, cs_s2;
	logic [CW-1:0] bit_count;
	logic [BYTE_W-1:0] shift;
	logic rx_valid;
	logic [BYTE_W-1:0] rx_byte;

	wire logic frame = ~cs_s2;
	wire logic rise = sclk_s2 & ~sclk_s3;
	wire logic fall = ~sclk_s2 & sclk_s3;
	wire logic [BYTE_W-1:0] next_shift = {shift[BYTE_W-2:0], si_s2};
	wire logic [CW-1:0] next_count = (bit_count == LAST) ? '0 : bit_count + 1'b1;
	wire logic [CW-1:0] out_index = LAST - bit_count;

	assign bus.frame_active = frame;
	assign bus.rx_valid = rx_valid;
	assign bus.rx_byte = rx_byte;

	always_ff @(posedge clk)
	begin
		sclk_s1 <= sclk;
		sclk_s2 <= sclk_s1;
		sclk_s3 <= sclk_s2;
		si_s1 <= si;
		si_s2 <= si_s1;
		cs_s1 <= cs_n;
		cs_s2 <= cs_s1;
	end

	always_ff @(posedge clk)
	begin
		if (rst || !frame)
		begin
			bit_count <= '0;
			shift <= '0;
		end
		else if (rise)
		begin
			bit_count <= next_count;
			shift <= next_shift;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_valid <= 1'b0;
			rx_byte <= '0;
		end
		else
		begin
			rx_valid <= frame && rise && (bit_count == LAST);
			if (frame && rise && (bit_count == LAST))
				rx_byte <= next_shift;
		end
	end

	// Output bit changes on falling clock, MSB first
	always_ff @(posedge clk)
	begin
		if (rst || !frame)
			so <= 1'b0;
		else if (fall)
			so <= bus.tx_byte[out_index];
	end
endmodule

// ### core/synth_modem_config_regs.sv
// Synthesizer and modem configuration register bank behind the serial host port
`timescale 1ns/1ps
module synth_modem_config_regs
	import synth_modem_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic SCLK,
	input wire logic SI,
	input wire logic CS_N,
	output logic SO,
	output logic [WORD_W-1:0] CARRIER_WORD,
	output logic [WORD_W-1:0] SYNTH_WORD,
	output logic [DECIM_W-1:0] DECIM_RATIO,
	output logic [WORD_W-1:0] RATE_STEP,
	output logic DC_BLOCK_BYPASS,
	output logic [2:0] MOD_SELECT,
	output logic MOD_IS_2FSK,
	output logic MOD_IS_GFSK,
	output logic MOD_IS_ASK,
	output logic MOD_IS_MSK
);
	host_byte_if #(.BYTE_W(BYTE_W)) link ();

	host_byte_port #(.BYTE_W(BYTE_W)) u_port (
		.clk(MCLK),
		.rst(RST),
		.sclk(SCLK),
		.si(SI),
		.cs_n(CS_N),
		.so(SO),
		.bus(link.port)
	);

	logic [7:0] synth_carrier_word_offset;
	logic [7:0] carrier_word_high;
	logic [7:0] carrier_word_middle;
	logic [7:0] carrier_word_low;
	logic [7:0] filter_bw_and_rate_exp;
	logic [7:0] symbol_rate_mantissa;
	logic [7:0] modem_format_control;
	frame_state_e state;
	logic [ADDR_W-1:0] addr;
	logic is_read;
	logic is_burst;

	function automatic logic [7:0] read_value(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_CARRIER_WORD_OFFSET: read_value = synth_carrier_word_offset;
			ADDR_CARRIER_HIGH: read_value = carrier_word_high;
			ADDR_CARRIER_MIDDLE: read_value = carrier_word_middle;
			ADDR_CARRIER_LOW: read_value = carrier_word_low;
			ADDR_FILTER_RATE: read_value = filter_bw_and_rate_exp;
			ADDR_RATE_MANTISSA: read_value = symbol_rate_mantissa;
			ADDR_MODEM_FORMAT: read_value = modem_format_control;
			default: read_value = 8'h00;
		endcase
	endfunction

	wire logic in_data = (state == ST_DATA);
	wire logic wr_en = link.rx_valid && in_data && !is_read;
	wire logic [7:0] wdata = link.rx_byte;
	assign link.tx_byte = (in_data && is_read) ? read_value(addr) : 8'h00;

	// Host framing: header byte, then one or a burst of data bytes
	always_ff @(posedge MCLK)
	begin
		if (RST || !link.frame_active)
		begin
			state <= ST_HEADER;
			addr <= '0;
			is_read <= 1'b0;
			is_burst <= 1'b0;
		end
		else if (link.rx_valid)
		begin
			unique case (state)
				ST_HEADER:
				begin
					addr <= link.rx_byte[ADDR_W-1:0];
					is_read <= link.rx_byte[HDR_READ_BIT];
					is_burst <= link.rx_byte[HDR_BURST_BIT];
					state <= ST_DATA;
				end
				ST_DATA:
				begin
					addr <= addr + 1'b1;
					if (!is_burst)
						state <= ST_HEADER;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			synth_carrier_word_offset <= RST_CARRIER_WORD_OFFSET;
			carrier_word_high <= RST_CARRIER_HIGH;
			carrier_word_middle <= RST_CARRIER_MIDDLE;
			carrier_word_low <= RST_CARRIER_LOW;
			filter_bw_and_rate_exp <= RST_FILTER_RATE;
			symbol_rate_mantissa <= RST_RATE_MANTISSA;
			modem_format_control <= RST_MODEM_FORMAT;
		end
		else if (wr_en)
		begin
			if (addr == ADDR_CARRIER_WORD_OFFSET)
				synth_carrier_word_offset <= wdata & MASK_FULL;
			if (addr == ADDR_CARRIER_HIGH)
				carrier_word_high <= wdata & MASK_CARRIER_HIGH;
			if (addr == ADDR_CARRIER_MIDDLE)
				carrier_word_middle <= wdata & MASK_FULL;
			if (addr == ADDR_CARRIER_LOW)
				carrier_word_low <= wdata & MASK_FULL;
			if (addr == ADDR_FILTER_RATE)
				filter_bw_and_rate_exp <= wdata & MASK_FULL;
			if (addr == ADDR_RATE_MANTISSA)
				symbol_rate_mantissa <= wdata & MASK_FULL;
			if (addr == ADDR_MODEM_FORMAT)
				modem_format_control <= wdata & MASK_MODEM_FORMAT;
		end
	end

	wire logic [WORD_W-1:0] base_word = {2'b00, carrier_word_high[HIGH_WORD_HI:0],
		carrier_word_middle, carrier_word_low};
	wire logic signed [WORD_W-1:0] offset_ext = WORD_W'(signed'(synth_carrier_word_offset));
	wire logic [WORD_W-1:0] next_synth = base_word + WORD_W'(offset_ext <<< OFFSET_SHIFT);
	// decimation 8 * (4 + mantissa) * 2^exponent
	wire logic [1:0] bw_exp = filter_bw_and_rate_exp[BW_EXP_HI:BW_EXP_LO];
	wire logic [1:0] bw_mant = filter_bw_and_rate_exp[BW_MANT_HI:BW_MANT_LO];
	wire logic [2:0] bw_sum = DECIM_BASE + {1'b0, bw_mant};
	wire logic [DECIM_W-1:0] next_decim = DECIM_W'(DECIM_W'(bw_sum) << (DECIM_SCALE_SHIFT + int'(bw_exp)));
	wire logic [3:0] rate_exp = filter_bw_and_rate_exp[RATE_EXP_HI:RATE_EXP_LO];
	wire logic [8:0] rate_mant = RATE_HIDDEN_ONE | {1'b0, symbol_rate_mantissa};
	wire logic [WORD_W-1:0] next_rate = WORD_W'(rate_mant) << rate_exp;
	wire logic [2:0] mod_field = modem_format_control[MOD_HI:MOD_LO];

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			CARRIER_WORD <= '0;
			SYNTH_WORD <= '0;
			DECIM_RATIO <= '0;
			RATE_STEP <= '0;
			DC_BLOCK_BYPASS <= 1'b0;
			MOD_SELECT <= MOD_2FSK;
			MOD_IS_2FSK <= 1'b0;
			MOD_IS_GFSK <= 1'b0;
			MOD_IS_ASK <= 1'b0;
			MOD_IS_MSK <= 1'b0;
		end
		else
		begin
			CARRIER_WORD <= base_word;
			SYNTH_WORD <= next_synth;
			DECIM_RATIO <= next_decim;
			RATE_STEP <= next_rate;
			DC_BLOCK_BYPASS <= modem_format_control[DC_BYPASS_BIT];
			MOD_SELECT <= mod_field;
			MOD_IS_2FSK <= (mod_field == MOD_2FSK);
			MOD_IS_GFSK <= (mod_field == MOD_GFSK);
			MOD_IS_ASK <= (mod_field == MOD_ASK);
			MOD_IS_MSK <= (mod_field == MOD_MSK);
		end
	end

	sequence wr_at(logic [ADDR_W-1:0] a);
		wr_en && (addr == a);
	endsequence

	a_high_top_zero: assert property (@(posedge MCLK) disable iff (RST)
		wr_at(ADDR_CARRIER_HIGH) |=> ##1 (CARRIER_WORD[WORD_W-1:WORD_W-2] == 2'b00)
			&& (CARRIER_WORD[21:16] == $past(wdata[HIGH_WORD_HI:0], 2)))
		else $error("high carrier byte top bits not zero");

	a_base_word_low: assert property (@(posedge MCLK) disable iff (RST)
		wr_at(ADDR_CARRIER_LOW) |=> ##1 (CARRIER_WORD[7:0] == $past(wdata, 2)))
		else $error("low carrier byte not in base word");

	a_offset_added: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) |-> SYNTH_WORD == WORD_W'($past(base_word) + WORD_W'($past(offset_ext) * 4)))
		else $error("synth word lacks scaled offset");

	a_decim_ratio: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) |-> DECIM_RATIO == DECIM_W'(8 * (4 + int'($past(bw_mant))) * (1 << int'($past(bw_exp)))))
		else $error("decimation ratio wrong");

	a_rate_exp_reset: assert property (@(posedge MCLK)
		$fell(RST) |-> rate_exp == RST_RATE_EXP)
		else $error("rate exponent reset not twelve");

	a_mantissa_reset: assert property (@(posedge MCLK)
		$fell(RST) |-> symbol_rate_mantissa == RST_RATE_MANTISSA)
		else $error("rate mantissa reset wrong");

	a_rate_step: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) |-> RATE_STEP == WORD_W'((256 + int'($past(symbol_rate_mantissa))) << $past(rate_exp)))
		else $error("symbol rate step wrong");

	a_dc_bypass: assert property (@(posedge MCLK) disable iff (RST)
		wr_at(ADDR_MODEM_FORMAT) |=> ##1 (DC_BLOCK_BYPASS == $past(wdata[DC_BYPASS_BIT], 2)))
		else $error("dc bypass not following bit 7");

	a_mod_field: assert property (@(posedge MCLK) disable iff (RST)
		wr_at(ADDR_MODEM_FORMAT) |=> ##1 (MOD_SELECT == $past(wdata[MOD_HI:MOD_LO], 2)))
		else $error("modulation field wrong");

	a_mod_decode: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) |-> (MOD_IS_MSK == (MOD_SELECT == 3'h7)) && (MOD_IS_ASK == (MOD_SELECT == 3'h3))
			&& (MOD_IS_GFSK == (MOD_SELECT == 3'h1)) && (MOD_IS_2FSK == (MOD_SELECT == 3'h0)))
		else $error("modulation decode wrong");

	a_reserved_ignored: assert property (@(posedge MCLK) disable iff (RST)
		wr_at(ADDR_MODEM_FORMAT) |=> (modem_format_control[3:0] == 4'h0))
		else $error("reserved modem bits written");
endmodule

// ### bench/synth_modem_config_regs_tb.sv
// Self-checking bench for the synthesizer and modem configuration bank
`timescale 1ns/1ps
module synth_modem_config_regs_tb import synth_modem_pkg::*;;
	logic mclk;
	logic rst;
	logic sclk;
	logic si;
	logic cs_n;
	logic so;
	logic [WORD_W-1:0] carrier_word;
	logic [WORD_W-1:0] synth_word;
	logic [DECIM_W-1:0] decim_ratio;
	logic [WORD_W-1:0] rate_step;
	logic dc_block_bypass;
	logic [2:0] mod_select;
	logic is_2fsk;
	logic is_gfsk;
	logic is_ask;
	logic is_msk;
	int err_count;
	int check_count;
	int cycles;

	synth_modem_config_regs uut (.MCLK(mclk), .RST(rst), .SCLK(sclk), .SI(si), .CS_N(cs_n), .SO(so),
		.CARRIER_WORD(carrier_word), .SYNTH_WORD(synth_word), .DECIM_RATIO(decim_ratio),
		.RATE_STEP(rate_step), .DC_BLOCK_BYPASS(dc_block_bypass), .MOD_SELECT(mod_select),
		.MOD_IS_2FSK(is_2fsk), .MOD_IS_GFSK(is_gfsk), .MOD_IS_ASK(is_ask), .MOD_IS_MSK(is_msk));

	always #5 mclk = ~mclk;

	// About 100 frames of 150 cycles each; ceiling leaves ample margin
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_count++;
			$display("[ERR] run length expected finish got hang");
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [23:0] want, input logic [23:0] got);
		check_count++;
		if (got !== want)
		begin
			err_count++;
			$display("[ERR] %s expected %h got %h", name, want, got);
		end
	endtask

	// Mode 0: data set while clock low, taken on the rise
	task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			@(negedge mclk);
			sclk = 1'b0;
			si = tx[i];
			repeat (4) @(negedge mclk);
			sclk = 1'b1;
			rx[i] = so;
			repeat (3) @(negedge mclk);
		end
	endtask

	task automatic xfer(input logic [7:0] hdr, input logic [7:0] tx, output logic [7:0] rx);
		logic [7:0] status;
		@(negedge mclk);
		cs_n = 1'b0;
		repeat (4) @(negedge mclk);
		spi_byte(hdr, status);
		spi_byte(tx, rx);
		@(negedge mclk);
		sclk = 1'b0;
		repeat (4) @(negedge mclk);
		cs_n = 1'b1;
		repeat (8) @(negedge mclk);
	endtask

	// Burst frame: header, then two data bytes at rising addresses
	task automatic burst2(input logic [7:0] hdr, input logic [7:0] tx0, input logic [7:0] tx1,
		output logic [7:0] rx0, output logic [7:0] rx1);
		logic [7:0] status;
		@(negedge mclk);
		cs_n = 1'b0;
		repeat (4) @(negedge mclk);
		spi_byte(hdr, status);
		spi_byte(tx0, rx0);
		spi_byte(tx1, rx1);
		@(negedge mclk);
		sclk = 1'b0;
		repeat (4) @(negedge mclk);
		cs_n = 1'b1;
		repeat (8) @(negedge mclk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] r;
		xfer({2'b00, a}, d, r);
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		xfer({2'b10, a}, 8'h00, d);
	endtask

	task automatic test_defaults(input string label);
		logic [7:0] d;
		logic [7:0] want [7];
		want = '{8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h00};
		for (int i = 0; i < 7; i++)
		begin
			rd(ADDR_CARRIER_WORD_OFFSET + 6'(i), d);
			chk("default register", {16'h0000, want[i]}, {16'h0000, d});
		end
		chk("carrier word", 24'h1E_C4EC, carrier_word);
		chk("synth word", 24'h1E_C4EC, synth_word);
		chk("decimation", 24'h00_0080, {15'h0000, decim_ratio});
		chk("rate step", 24'h12_2000, rate_step);
		chk("modulation", 24'h00_0000, {21'h00_0000, mod_select});
		chk("2fsk flag", 24'h00_0001, {23'h00_0000, is_2fsk});
		chk("dc bypass", 24'h00_0000, {23'h00_0000, dc_block_bypass});
		$display("%s done", label);
	endtask

	task automatic test_readonly();
		logic [7:0] d;
		wr(ADDR_CARRIER_HIGH, 8'hFF);
		wr(ADDR_CARRIER_MIDDLE, 8'h12);
		wr(ADDR_CARRIER_LOW, 8'h34);
		rd(ADDR_CARRIER_HIGH, d);
		chk("high byte", 24'h00_003F, {16'h0000, d});
		chk("carrier word", 24'h3F_1234, carrier_word);
		wr(ADDR_MODEM_FORMAT, 8'hFF);
		rd(ADDR_MODEM_FORMAT, d);
		chk("modem format", 24'h00_00F0, {16'h0000, d});
		chk("dc bypass", 24'h00_0001, {23'h00_0000, dc_block_bypass});
		wr(6'h13, 8'h5A);
		rd(6'h13, d);
		chk("unmapped", 24'h00_0000, {16'h0000, d});
		$display("read-only test done");
	endtask

	task automatic test_offset();
		logic [7:0] offs [3];
		logic [23:0] want;
		offs = '{8'h7F, 8'h80, 8'hFF};
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_CARRIER_WORD_OFFSET, offs[i]);
			want = 24'h3F_1234 + {{14{offs[i][7]}}, offs[i], 2'b00};
			chk("synth word", want, synth_word);
			chk("carrier word", 24'h3F_1234, carrier_word);
		end
		$display("offset test done");
	endtask

	task automatic test_burst();
		logic [7:0] d0;
		logic [7:0] d1;
		burst2({2'b01, ADDR_CARRIER_MIDDLE}, 8'hAB, 8'hCD, d0, d1);
		chk("burst carrier word", 24'h3F_ABCD, carrier_word);
		burst2({2'b11, ADDR_CARRIER_MIDDLE}, 8'h00, 8'h00, d0, d1);
		chk("burst middle byte", 24'h00_00AB, {16'h0000, d0});
		chk("burst low byte", 24'h00_00CD, {16'h0000, d1});
		$display("burst test done");
	endtask

	task automatic test_modes();
		logic [2:0] c;
		for (int i = 0; i < 8; i++)
		begin
			c = 3'(i);
			wr(ADDR_MODEM_FORMAT, {c[1], c, 4'h0});
			chk("modulation", {21'h00_0000, c}, {21'h00_0000, mod_select});
			chk("2fsk flag", {23'h00_0000, c == 3'h0}, {23'h00_0000, is_2fsk});
			chk("gfsk flag", {23'h00_0000, c == 3'h1}, {23'h00_0000, is_gfsk});
			chk("ask flag", {23'h00_0000, c == 3'h3}, {23'h00_0000, is_ask});
			chk("msk flag", {23'h00_0000, c == 3'h7}, {23'h00_0000, is_msk});
			chk("dc bypass", {23'h00_0000, c[1]}, {23'h00_0000, dc_block_bypass});
		end
		$display("modulation test done");
	endtask

	task automatic test_rates();
		logic [3:0] n;
		logic [7:0] mant;
		logic [7:0] d;
		logic [23:0] want;
		wr(ADDR_MODEM_FORMAT, 8'h00);
		chk("dc bypass", 24'h00_0000, {23'h00_0000, dc_block_bypass});
		for (int i = 0; i < 16; i++)
		begin
			n = 4'(i);
			mant = {n, ~n};
			wr(ADDR_FILTER_RATE, {n, n});
			wr(ADDR_RATE_MANTISSA, mant);
			want = (24'h00_0020 + {20'h0_0000, n[1:0], 3'b000}) << n[3:2];
			chk("decimation", want, {15'h0000, decim_ratio});
			want = (24'h00_0100 + {16'h0000, mant}) << n;
			chk("rate step", want, rate_step);
			rd(ADDR_FILTER_RATE, d);
			chk("rate exponent", {20'h0_0000, n}, {20'h0_0000, d[3:0]});
			rd(ADDR_RATE_MANTISSA, d);
			chk("rate mantissa", {16'h0000, mant}, {16'h0000, d});
		end
		$display("rate test done");
	endtask

	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
		cs_n = 1'b1;
		err_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		test_defaults("reset test");
		test_readonly();
		test_offset();
		test_burst();
		test_modes();
		test_rates();
		rst = 1'b1;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		test_defaults("second reset test");
		tally_and_finish();
	end
endmodule
